// ### shared/fdrm_defs.vh
// constants for the direct read mode controller
`ifndef FDRM_DEFS_VH
`define FDRM_DEFS_VH

`define FDRM_CLK_MHZ 250
`define FDRM_T_VSL_US 300
`define FDRM_T_VSL_4K_US 4500
`define FDRM_T_VSL_32K_US 36000
`define FDRM_T_POLL_WAIT_US 100

`define FDRM_CMD_FAST_READ 8'h0b
`define FDRM_CMD_DOUT_READ 8'h3b
`define FDRM_CMD_QOUT_READ 8'h6b
`define FDRM_CMD_DIO_READ 8'hbb
`define FDRM_CMD_QIO_READ 8'heb
`define FDRM_CMD_RD_STATUS 8'h05
`define FDRM_CMD_RD_FLAG 8'h70
`define FDRM_CMD_WR_EN 8'h06
`define FDRM_CMD_WR_DIS 8'h04
`define FDRM_CMD_RST_ARM 8'h66
`define FDRM_CMD_RST_EXE 8'h99
`define FDRM_CMD_WR_VCFG 8'h81

`define FDRM_VCFG_MODE_BIT 3
`define FDRM_NV_MODE_OFF 3'h7
`define FDRM_SR_BUSY_BIT 0
`define FDRM_SR_WEL_BIT 1
`define FDRM_FSR_READY_BIT 7
`define FDRM_ADDR_BITS 6'h18
`define FDRM_CMD_BITS 6'h08

`define FDRM_PROTO_EXT 2'h0
`define FDRM_PROTO_DUAL 2'h1
`define FDRM_PROTO_QUAD 2'h2

`define FDRM_RESCUE_A 6'h07
`define FDRM_RESCUE_B 6'h09
`define FDRM_RESCUE_C 6'h0d
`define FDRM_RESCUE_D 6'h11
`define FDRM_RESCUE_E 6'h19
`define FDRM_RESCUE_F 6'h21

`endif

// ### design/fdrm_ctrl.v
// direct read mode entry, exit, rescue and power-up control of a serial flash
// Notes on behaviour
// - volatile config bit 3 written 0 arms direct read mode, not yet active.
// - armed mode becomes active when next quick read confirm bit is 0.
// - active mode starts each access from address alone after select toggle.
// - confirm bit 0 keeps mode; confirm bit 1 leaves to normal commands.
// - leaving the mode sets volatile config bit 3 back to 1.
// - basic variant enters mode on confirm 0 without the volatile bit.
// - nonvolatile bits [11:9] select power-up straight into direct read mode.
// - confirm bit sampled from io_line_zero in first dummy clock.
// - other data lines ignored during that first dummy clock.
// - reset pin low pulse ends mode, restores nonvolatile state; quad only deselected.
// - rescue bursts end mode only; reset arm then execute resets device.
// - below power-on threshold logic held in reset, no instruction answered.
// - during power-up init only status and flag status reads accepted.
// - after power-up latches cleared and lock pair reads (0,0).
// - flag ready bit 0 while internal operation runs, 1 when done.
// - power-up polling on single line; commands on line zero, data line one.
// - ready time stretches to 4.5ms or 36ms after interrupted subsector erase.
`timescale 1ns/1ps
`default_nettype none
`include "fdrm_defs.vh"

module fdrm_ctrl #(
    parameter READY_CYC = `FDRM_T_VSL_US * `FDRM_CLK_MHZ,
    parameter READY_4K_CYC = `FDRM_T_VSL_4K_US * `FDRM_CLK_MHZ,
    parameter READY_32K_CYC = `FDRM_T_VSL_32K_US * `FDRM_CLK_MHZ
) (
    input wire clk_sys,
    input wire rst_b,
    input wire sclk,
    input wire cs_b,
    input wire [3:0] dq_in,
    input wire hw_rst_b,
    input wire reset_pin_en,
    input wire [1:0] proto,
    input wire [2:0] nv_mode_sel,
    input wire basic_variant,
    input wire [1:0] erase_intr,
    input wire op_busy,
    output reg io_line_one,
    output reg io_line_one_oe_b,
    output reg direct_read_mode,
    output reg vcfg_mode_b,
    output reg wel,
    output reg wip,
    output reg write_lock,
    output reg lock_down,
    output reg dev_ready,
    output reg cmd_rejected,
    output reg soft_reset
);

    localparam S_IDLE = 3'h0;
    localparam S_CMD = 3'h1;
    localparam S_ADDR = 3'h2;
    localparam S_DUMMY = 3'h3;
    localparam S_DATA = 3'h4;
    localparam S_WDATA = 3'h5;
    localparam S_SKIP = 3'h6;

    // two-stage synchronisers, third stage for edges
    reg [7:0] sync1;
    reg [7:0] sync2;
    reg sclk_d;
    reg cs_d;
    reg hrst_d;

    wire sclk_s = sync2[0];
    wire cs_s = sync2[1];
    wire hrst_s = sync2[2];
    wire [3:0] dq_s = sync2[7:4];
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire frame_start = ~cs_s & cs_d;
    wire frame_end = cs_s & ~cs_d;

    reg [2:0] state;
    reg [7:0] cmd;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg [5:0] bit_cnt;
    reg [5:0] clk_cnt;
    reg ones;
    reg cmd_ok;
    reg byte_ok;
    reg rst_armed;
    reg booted;
    reg init_busy;
    reg [23:0] init_cnt;

    wire nv_boot_mode = (nv_mode_sel != `FDRM_NV_MODE_OFF);
    wire armed = ~vcfg_mode_b | basic_variant;

    // polling during init is forced to one line
    reg [5:0] lanes;
    always @* begin
        if (init_busy) begin
            lanes = 6'h01;
        end else if (proto == `FDRM_PROTO_QUAD) begin
            lanes = 6'h04;
        end else if (proto == `FDRM_PROTO_DUAL) begin
            lanes = 6'h02;
        end else begin
            lanes = 6'h01;
        end
    end

    reg [7:0] shifted;
    always @* begin
        case (lanes)
            6'h04: shifted = {shift_in[3:0], dq_s[3:0]};
            6'h02: shifted = {shift_in[5:0], dq_s[1:0]};
            default: shifted = {shift_in[6:0], dq_s[0]};
        endcase
    end

    wire [5:0] next_bit_cnt = bit_cnt + lanes;
    wire is_read = (shifted == `FDRM_CMD_FAST_READ) || (shifted == `FDRM_CMD_DOUT_READ) ||
        (shifted == `FDRM_CMD_QOUT_READ) || (shifted == `FDRM_CMD_DIO_READ) ||
        (shifted == `FDRM_CMD_QIO_READ);
    wire is_poll = (shifted == `FDRM_CMD_RD_STATUS) || (shifted == `FDRM_CMD_RD_FLAG);
    wire busy_now = init_busy | op_busy;
    wire rescue_len = (clk_cnt == `FDRM_RESCUE_A) || (clk_cnt == `FDRM_RESCUE_B) ||
        (clk_cnt == `FDRM_RESCUE_C) || (clk_cnt == `FDRM_RESCUE_D) ||
        (clk_cnt == `FDRM_RESCUE_E) || (clk_cnt == `FDRM_RESCUE_F);
    // reset pulse, quad only while deselected
    wire pin_reset = reset_pin_en & ~hrst_s & hrst_d &
        ((proto != `FDRM_PROTO_QUAD) | cs_s);
    wire sw_reset = frame_end & (state == S_SKIP) & cmd_ok & rst_armed &
        (cmd == `FDRM_CMD_RST_EXE);

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 8'h06;
            sync2 <= 8'h06;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            hrst_d <= 1'b1;
        end else begin
            sync1 <= {dq_in, 1'b0, hw_rst_b, cs_b, sclk};
            sync2 <= sync1;
            sclk_d <= sclk_s;
            cs_d <= cs_s;
            hrst_d <= hrst_s;
        end
    end

    // power-on reset holds everything; ready time by erase history
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            booted <= 1'b0;
            init_busy <= 1'b1;
            init_cnt <= 24'h000000;
            dev_ready <= 1'b0;
        end else if (!booted) begin
            booted <= 1'b1;
            if (erase_intr[1]) begin
                init_cnt <= READY_32K_CYC[23:0];
            end else if (erase_intr[0]) begin
                init_cnt <= READY_4K_CYC[23:0];
            end else begin
                init_cnt <= READY_CYC[23:0];
            end
        end else if (init_busy) begin
            if (init_cnt <= 24'h000001) begin
                init_busy <= 1'b0;
                dev_ready <= 1'b1;
            end else begin
                init_cnt <= init_cnt - 24'h000001;
            end
        end
    end

    // busy status bit wip follows the running operation
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wip <= 1'b0;
        end else begin
            wip <= op_busy;
        end
    end

    // dynamic protection pair comes up cleared
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            write_lock <= 1'b0;
            lock_down <= 1'b0;
        end else if (pin_reset | sw_reset) begin
            write_lock <= 1'b0;
            lock_down <= 1'b0;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            cmd <= 8'h00;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            bit_cnt <= 6'h00;
            clk_cnt <= 6'h00;
            ones <= 1'b0;
            cmd_ok <= 1'b0;
            byte_ok <= 1'b0;
            rst_armed <= 1'b0;
            direct_read_mode <= 1'b0;
            vcfg_mode_b <= 1'b1;
            wel <= 1'b0;
            io_line_one <= 1'b0;
            io_line_one_oe_b <= 1'b1;
            cmd_rejected <= 1'b0;
            soft_reset <= 1'b0;
        end else begin
            cmd_rejected <= 1'b0;
            soft_reset <= 1'b0;
            if (!booted) begin
                // nonvolatile selection boots straight into the mode
                direct_read_mode <= nv_boot_mode;
            end else if (pin_reset | sw_reset) begin
                direct_read_mode <= nv_boot_mode;
                vcfg_mode_b <= 1'b1;
                wel <= 1'b0;
                rst_armed <= 1'b0;
                state <= S_IDLE;
                io_line_one_oe_b <= 1'b1;
                soft_reset <= 1'b1;
            end else if (frame_start) begin
                clk_cnt <= 6'h00;
                ones <= 1'b1;
                bit_cnt <= 6'h00;
                cmd_ok <= 1'b0;
                byte_ok <= 1'b0;
                if (direct_read_mode) begin
                    state <= S_ADDR;
                    cmd <= `FDRM_CMD_FAST_READ;
                end else begin
                    state <= S_CMD;
                end
            end else if (frame_end) begin
                state <= S_IDLE;
                io_line_one_oe_b <= 1'b1;
                if (ones && rescue_len) begin
                    direct_read_mode <= 1'b0;
                    vcfg_mode_b <= 1'b1;
                end else if (state == S_SKIP && cmd_ok) begin
                    rst_armed <= (cmd == `FDRM_CMD_RST_ARM);
                    if (cmd == `FDRM_CMD_WR_EN) begin
                        wel <= 1'b1;
                    end else if (cmd == `FDRM_CMD_WR_DIS) begin
                        wel <= 1'b0;
                    end else if (cmd == `FDRM_CMD_WR_VCFG && byte_ok && wel) begin
                        vcfg_mode_b <= shift_in[`FDRM_VCFG_MODE_BIT];
                        wel <= 1'b0;
                    end
                end
            end else if (!cs_s && sclk_rise) begin
                if (clk_cnt != 6'h3f) begin
                    clk_cnt <= clk_cnt + 6'h01;
                end
                ones <= ones & dq_s[0] & dq_s[3];
                case (state)
                    S_CMD: begin
                        shift_in <= shifted;
                        bit_cnt <= next_bit_cnt;
                        if (next_bit_cnt == `FDRM_CMD_BITS) begin
                            cmd <= shifted;
                            bit_cnt <= 6'h00;
                            if (init_busy && !is_poll) begin
                                state <= S_SKIP;
                                cmd_rejected <= 1'b1;
                            end else if (is_read) begin
                                state <= S_ADDR;
                            end else if (is_poll) begin
                                state <= S_DATA;
                                if (shifted == `FDRM_CMD_RD_STATUS) begin
                                    shift_out <= {6'h00, wel, busy_now};
                                end else begin
                                    shift_out <= {~busy_now, 7'h00};
                                end
                            end else if (shifted == `FDRM_CMD_WR_VCFG) begin
                                state <= S_WDATA;
                                cmd_ok <= 1'b1;
                            end else begin
                                state <= S_SKIP;
                                cmd_ok <= 1'b1;
                            end
                        end
                    end
                    S_ADDR: begin
                        bit_cnt <= next_bit_cnt;
                        if (next_bit_cnt >= `FDRM_ADDR_BITS) begin
                            state <= S_DUMMY;
                        end
                    end
                    S_DUMMY: begin
                        state <= S_SKIP;
                        if (direct_read_mode) begin
                            // keep on 0, leave on 1
                            if (dq_s[0]) begin
                                direct_read_mode <= 1'b0;
                                vcfg_mode_b <= 1'b1;
                            end
                        end else if (armed && !dq_s[0]) begin
                            direct_read_mode <= 1'b1;
                        end
                    end
                    S_WDATA: begin
                        shift_in <= shifted;
                        bit_cnt <= next_bit_cnt;
                        if (next_bit_cnt == `FDRM_CMD_BITS) begin
                            byte_ok <= 1'b1;
                            state <= S_SKIP;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end else if (!cs_s && sclk_fall && state == S_DATA) begin
                // status byte repeats while clocked
                io_line_one <= shift_out[7];
                io_line_one_oe_b <= 1'b0;
                shift_out <= {shift_out[6:0], shift_out[7]};
            end
        end
    end

endmodule // fdrm_ctrl
`default_nettype wire

// ### tb/fdrm_ctrl_sva.sv
// port assertions for the direct read mode controller
`timescale 1ns/1ps
`default_nettype none
module fdrm_ctrl_sva #(
    parameter int READY_CYC = 300,
    parameter int READY_4K_CYC = 600,
    parameter int READY_32K_CYC = 900
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic hw_rst_b,
    input wire logic reset_pin_en,
    input wire logic [2:0] nv_mode_sel,
    input wire logic [1:0] erase_intr,
    input wire logic op_busy,
    input wire logic io_line_one_oe_b,
    input wire logic direct_read_mode,
    input wire logic vcfg_mode_b,
    input wire logic wel,
    input wire logic wip,
    input wire logic write_lock,
    input wire logic lock_down,
    input wire logic dev_ready,
    input wire logic cmd_rejected,
    input wire logic soft_reset
);
    int cnt;
    int lim;
    logic [1:0] ei;
    // cycles since reset release, erase flags caught at start
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            ei <= 2'h0;
        end else begin
            cnt <= cnt + 1;
            if (cnt == 0)
                ei <= erase_intr;
        end
    end
    assign lim = ei[1] ? READY_32K_CYC : (ei[0] ? READY_4K_CYC : READY_CYC);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_pin_drop;
        dev_ready && reset_pin_en && cs_b && $fell(hw_rst_b);
    endsequence
    sequence s_reloaded;
        !wel && direct_read_mode == (nv_mode_sel != 3'h7);
    endsequence
    AST_WIP_RISE: assert property ($rose(op_busy) |=> wip)
        else $error("wip missed op_busy");
    AST_LATCH_CLEAR: assert property (cnt == 1 |->
        !wel && !wip && !write_lock && !lock_down && vcfg_mode_b) else $error("boot latches");
    AST_NV_BOOT: assert property (cnt == 1 |-> direct_read_mode == (nv_mode_sel != 3'h7))
        else $error("boot mode wrong");
    AST_READY_EARLY: assert property ($rose(dev_ready) |-> cnt >= lim)
        else $error("ready too early");
    AST_READY_LATE: assert property (cnt == lim + 4 |-> dev_ready)
        else $error("ready too late");
    AST_READY_HOLD: assert property (dev_ready |=> dev_ready)
        else $error("ready dropped");
    AST_REJ_INIT: assert property (cmd_rejected |-> !dev_ready)
        else $error("refusal after init");
    AST_REJ_PULSE: assert property (cmd_rejected |=> !cmd_rejected)
        else $error("refusal pulse too long");
    AST_EXIT_VCFG: assert property ($fell(direct_read_mode) |-> ##[0:1] vcfg_mode_b)
        else $error("mode bit not restored");
    AST_OE_IDLE: assert property (cs_b [*8] |-> io_line_one_oe_b)
        else $error("driving while deselected");
    AST_PIN_RESET: assert property (s_pin_drop |-> ##[1:6] soft_reset)
        else $error("pin reset ignored");
    AST_SOFT_RELOAD: assert property (soft_reset |-> ##[0:2] s_reloaded)
        else $error("reset did not reload");
endmodule // fdrm_ctrl_sva
`default_nettype wire

// ### tb/fdrm_host_model.sv
// host controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module fdrm_host_model (
    input wire logic clk_sys,
    input wire logic io_line_one,
    output logic sclk,
    output logic cs_b,
    output logic [3:0] dq
);
    logic [7:0] rx;
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        dq = 4'h5;
        rx = 8'h00;
    end
    task automatic tick(input logic [3:0] v);
        dq = v;
        repeat (6) @(negedge clk_sys);
        rx = {rx[6:0], io_line_one};
        sclk = 1'b1;
        repeat (6) @(negedge clk_sys);
        sclk = 1'b0;
    endtask
    task automatic frame(input logic [63:0] v, input int n, input logic [2:0] hi);
        @(negedge clk_sys);
        cs_b = 1'b0;
        for (int i = n - 1; i >= 0; i--)
            tick({hi, v[i]});
        repeat (6) @(negedge clk_sys);
        cs_b = 1'b1;
        dq = ~dq;
        repeat (12) @(negedge clk_sys);
    endtask
endmodule // fdrm_host_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the direct read mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int RC = 300;
    localparam int R4 = 600;
    localparam int R32 = 900;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic hw_rst_b = 1'b1, reset_pin_en = 1'b1, basic_variant = 1'b0, op_busy = 1'b0;
    logic [2:0] nv_mode_sel = 3'h7;
    logic [1:0] erase_intr = 2'h0;
    logic [1:0] proto = 2'h0;
    wire sclk, cs_b, io_line_one, io_line_one_oe_b, direct_read_mode, vcfg_mode_b, wel;
    wire wip, write_lock, lock_down, dev_ready, cmd_rejected, soft_reset;
    wire [3:0] dq_in;
    wire [7:0] hrx = fdrm_host_model_i.rx;
    int errors = 0, n_tests = 0, n_rej = 0, n_soft = 0;
    int rescue[6] = '{7, 9, 13, 17, 25, 33};
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (cmd_rejected === 1'b1) n_rej++;
        if (soft_reset === 1'b1) n_soft++;
    end
    fdrm_ctrl #(.READY_CYC(RC), .READY_4K_CYC(R4), .READY_32K_CYC(R32)) fdrm_ctrl_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
        .hw_rst_b(hw_rst_b), .reset_pin_en(reset_pin_en), .proto(proto),
        .nv_mode_sel(nv_mode_sel), .basic_variant(basic_variant), .erase_intr(erase_intr),
        .op_busy(op_busy), .io_line_one(io_line_one), .io_line_one_oe_b(io_line_one_oe_b),
        .direct_read_mode(direct_read_mode), .vcfg_mode_b(vcfg_mode_b), .wel(wel), .wip(wip),
        .write_lock(write_lock), .lock_down(lock_down), .dev_ready(dev_ready),
        .cmd_rejected(cmd_rejected), .soft_reset(soft_reset));
    fdrm_host_model fdrm_host_model_i (.clk_sys(clk_sys), .io_line_one(io_line_one),
        .sclk(sclk), .cs_b(cs_b), .dq(dq_in));
    function automatic logic boot_mode(input logic [2:0] nv);
        return nv != 3'h7;
    endfunction
    function automatic int ready_lim(input logic [1:0] ei);
        return ei[1] ? R32 : (ei[0] ? R4 : RC);
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic fr(input logic [63:0] v, input int n, input logic [2:0] hi);
        fdrm_host_model_i.frame(v, n, hi);
    endtask
    task automatic power_up(input logic [2:0] nv, input logic [1:0] ei);
        @(negedge clk_sys);
        rst_b = 1'b0;
        nv_mode_sel = nv;
        erase_intr = ei;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    initial begin
        #400000;
        errors++;
        close_out;
    end
    initial begin
        logic [23:0] a;
        logic [2:0] nv;
        logic [1:0] ei;
        int c;
        void'($urandom(52905));
        power_up(3'h7, 2'h0);
        chk("boot mode", direct_read_mode, boot_mode(3'h7));
        chk("boot latches", {wel, wip, write_lock, lock_down, vcfg_mode_b, dev_ready}, 8'h02);
        fr(64'h06, 8, 3'h0);
        chk("refusals", n_rej, 8'h01);
        fr({8'h70, 8'h00}, 16, 3'h0);
        chk("poll refusals", n_rej, 8'h01);
        chk("wel in init", wel, 8'h00);
        for (c = 0; c < 2000 && dev_ready !== 1'b1; c++)
            @(negedge clk_sys);
        chk("ready", dev_ready, 8'h01);
        $display("test power-up done");
        fr(64'h06, 8, 3'h0);
        fr({8'h05, 8'h00}, 16, 3'h0);
        chk("status wel", hrx[1], 8'h01);
        fr({8'h81, 8'hf7}, 16, 3'h0);
        chk("armed", {vcfg_mode_b, direct_read_mode}, 8'h00);
        a = $urandom;
        fr({8'h0b, a, 1'b0}, 33, 3'($urandom));
        chk("entered", direct_read_mode, 8'h01);
        repeat (3) begin
            a = $urandom;
            fr({a, 1'b0}, 25, 3'($urandom));
            chk("held", direct_read_mode, 8'h01);
        end
        fr({a, 1'b1}, 25, 3'h0);
        chk("left", {vcfg_mode_b, direct_read_mode}, 8'h02);
        fr({24'h000000, 1'b0}, 25, 3'h0);
        chk("no reentry", direct_read_mode, 8'h00);
        $display("test volatile entry done");
        for (int b = 1; b >= 0; b--) begin
            op_busy = b[0];
            repeat (2) begin
                fr({8'h70, 8'h00}, 16, 3'h0);
                chk("flag ready", hrx[7], {7'h00, ~b[0]});
            end
            chk("wip", wip, {7'h00, b[0]});
        end
        $display("test flag polling done");
        basic_variant = 1'b1;
        fr(64'h06, 8, 3'h0);
        foreach (rescue[k]) begin
            fr({8'h0b, a, 1'b0}, 33, 3'h0);
            chk("basic entry", direct_read_mode, 8'h01);
            fr({64{1'b1}}, rescue[k], 3'h7);
            chk("rescued", {vcfg_mode_b, direct_read_mode}, 8'h02);
        end
        chk("wel kept", wel, 8'h01);
        fr(64'h66, 8, 3'h0);
        fr(64'h99, 8, 3'h0);
        chk("soft resets", n_soft, 8'h01);
        chk("wel cleared", wel, 8'h00);
        $display("test rescue done");
        for (int en = 1; en >= 0; en--) begin
            reset_pin_en = en[0];
            fr({8'h0b, a, 1'b0}, 33, 3'h0);
            hw_rst_b = 1'b0;
            repeat (4) @(negedge clk_sys);
            hw_rst_b = 1'b1;
            repeat (8) @(negedge clk_sys);
            chk("pin reset", direct_read_mode, {7'h00, ~en[0]});
        end
        chk("pin pulses", n_soft, 8'h02);
        $display("test reset pin done");
        for (int p = 1; p <= 2; p++) begin
            proto = p[1:0];
            fr(64'h0, (24 >> p) + 1, 3'h7);
            chk("wide confirm", direct_read_mode, 8'h01);
        end
        reset_pin_en = 1'b1;
        fork
            fr(64'h0, 7, 3'h7);
            begin
                repeat (30) @(negedge clk_sys);
                hw_rst_b = 1'b0;
                repeat (4) @(negedge clk_sys);
                hw_rst_b = 1'b1;
            end
        join
        chk("quad selected", direct_read_mode, 8'h01);
        hw_rst_b = 1'b0;
        repeat (4) @(negedge clk_sys);
        hw_rst_b = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk("quad deselected", direct_read_mode, 8'h00);
        proto = 2'h0;
        $display("test wide protocols done");
        nv = 3'($urandom_range(6));
        ei = 2'($urandom_range(3, 1));
        power_up(nv, ei);
        chk("nv boot", direct_read_mode, boot_mode(nv));
        for (c = 2; c < 2000 && dev_ready !== 1'b1; c++)
            @(negedge clk_sys);
        chk("ready not early", c >= ready_lim(ei), 8'h01);
        chk("ready not late", c <= ready_lim(ei) + 5, 8'h01);
        a = $urandom;
        fr({a, 1'b1}, 25, 3'h0);
        chk("nv exit", {vcfg_mode_b, direct_read_mode}, 8'h02);
        $display("test boot mode done");
        close_out;
    end
endmodule // tb_top
bind fdrm_ctrl fdrm_ctrl_sva #(.READY_CYC(READY_CYC), .READY_4K_CYC(READY_4K_CYC),
    .READY_32K_CYC(READY_32K_CYC)) fdrm_ctrl_sva_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .cs_b(cs_b), .hw_rst_b(hw_rst_b), .reset_pin_en(reset_pin_en), .nv_mode_sel(nv_mode_sel),
    .erase_intr(erase_intr), .op_busy(op_busy), .io_line_one_oe_b(io_line_one_oe_b),
    .direct_read_mode(direct_read_mode), .vcfg_mode_b(vcfg_mode_b), .wel(wel), .wip(wip),
    .write_lock(write_lock), .lock_down(lock_down), .dev_ready(dev_ready),
    .cmd_rejected(cmd_rejected), .soft_reset(soft_reset));
`default_nettype wire
